/* File: verilog/timer_pkg.sv */
// constants for the one-shot and watchdog timer block
// assumes an 8-bit register port and tick strobes made elsewhere in the chip
package timer_pkg;
  // ---------------------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_GLOBAL_GATE       = 8'h3a;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL        = 8'ha0;
  localparam logic [7:0] OFS_ONESHOT_CONTROL         = 8'ha1;
  localparam logic [7:0] OFS_TIMER_TIMEOUT_FLAGS     = 8'ha2;
  localparam logic [7:0] OFS_ONESHOT_TERMINAL_COUNT  = 8'ha3;
  localparam logic [7:0] OFS_WATCHDOG_TERMINAL_COUNT = 8'ha4;
  localparam logic [7:0] OFS_TICK_SELECT             = 8'ha5;
  localparam logic [7:0] OFS_TIMER_IRQ_ENABLES       = 8'ha6;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_GATE_ON        = 0;
  localparam int BIT_WATCHDOG_RUN   = 0;
  localparam int BIT_WATCHDOG_RST   = 4;
  localparam int BIT_ONESHOT_START  = 0;
  localparam int BIT_ONESHOT_FLAG   = 0;
  localparam int BIT_WATCHDOG_FLAG  = 4;
  localparam int BIT_ONESHOT_IRQ    = 0;
  localparam int BIT_WATCHDOG_IRQ   = 4;
  localparam int LSB_ONESHOT_SEL    = 0;
  localparam int LSB_WATCHDOG_SEL   = 4;

  // ---------------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_LIMIT    = 8'hff;
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [1:0] RST_TICK_SEL = 2'h0;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  // tick select codes, one-shot: 32.768 kHz, 1024 Hz, 1 Hz, 1 minute
  // tick select codes, watchdog: 8 Hz, 1 Hz, 0.5 Hz, 1 minute
  localparam logic [1:0] SEL_TICK0 = 2'h0;
  localparam logic [1:0] SEL_TICK1 = 2'h1;
  localparam logic [1:0] SEL_TICK2 = 2'h2;
  localparam logic [1:0] SEL_TICK3 = 2'h3;
endpackage : timer_pkg

/* File: verilog/timer_block.sv */
// one-shot timer and restartable watchdog timer sharing one register bank
// assumes synchronous one-cycle tick strobes and a single-cycle register port
`timescale 1ns/100ps
module timer_block (
  input  wire logic       clk,            // 100 MHz system clock
  input  wire logic       rst_b,          // async reset, active low
  input  wire logic       ce,             // clock enable, low freezes all state
  input  wire logic [7:0] reg_addr,       // register offset
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  input  wire logic [7:0] reg_wdata,      // write data
  output logic      [7:0] reg_rdata,      // read data, one cycle after reg_rd
  input  wire logic       tick_32k,       // 32.768 kHz tick strobe
  input  wire logic       tick_1024,      // 1024 Hz tick strobe
  input  wire logic       tick_8hz,       // 8 Hz tick strobe
  input  wire logic       tick_1hz,       // 1 Hz tick strobe
  input  wire logic       tick_half_hz,   // 0.5 Hz tick strobe
  input  wire logic       tick_minute,    // one-minute tick strobe
  output logic            timer_irq       // interrupt request, active high level
);
  import timer_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       gate_on;
    logic       oneshot_start;
    logic [7:0] oneshot_cnt;
    logic [7:0] oneshot_limit;
    logic [1:0] oneshot_tick_sel;
    logic       oneshot_expired_flag;
    logic       oneshot_irq_on;
    logic       watchdog_run;
    logic [7:0] watchdog_cnt;
    logic [7:0] watchdog_limit;
    logic [1:0] watchdog_tick_sel;
    logic       watchdog_expired_flag;
    logic       watchdog_irq_on;
    logic       irq;
    logic [7:0] rdata;
  } timer_s;

  timer_s st_ff;
  timer_s nxt_st;

  // pick one of four tick strobes by a 2-bit select
  function automatic logic tick_pick(input logic [1:0] sel, input logic t0, input logic t1,
                                     input logic t2, input logic t3);
    logic r;
    r = 1'b0;
    case (sel)
      SEL_TICK0: r = t0;
      SEL_TICK1: r = t1;
      SEL_TICK2: r = t2;
      SEL_TICK3: r = t3;
      default:   r = 1'b0;
    endcase
    return r;
  endfunction : tick_pick

  // ---------------------------------------------------------------------------
  // decode and timer events
  // ---------------------------------------------------------------------------
  logic wr_gate;
  logic wr_wdog;
  logic wr_oneshot;
  logic wr_flags;
  logic wr_os_limit;
  logic wr_wd_limit;
  logic wr_sel;
  logic wr_irqen;
  logic os_tick;
  logic wd_tick;
  logic os_hit;
  logic wd_hit;

  assign wr_gate     = reg_wr && (reg_addr == OFS_TIMER_GLOBAL_GATE);
  assign wr_wdog     = reg_wr && (reg_addr == OFS_WATCHDOG_CONTROL);
  assign wr_oneshot  = reg_wr && (reg_addr == OFS_ONESHOT_CONTROL);
  assign wr_flags    = reg_wr && (reg_addr == OFS_TIMER_TIMEOUT_FLAGS);
  assign wr_os_limit = reg_wr && (reg_addr == OFS_ONESHOT_TERMINAL_COUNT);
  assign wr_wd_limit = reg_wr && (reg_addr == OFS_WATCHDOG_TERMINAL_COUNT);
  assign wr_sel      = reg_wr && (reg_addr == OFS_TICK_SELECT);
  assign wr_irqen    = reg_wr && (reg_addr == OFS_TIMER_IRQ_ENABLES);

  // tick selection per timer
  assign os_tick = tick_pick(st_ff.oneshot_tick_sel, tick_32k, tick_1024, tick_1hz, tick_minute);
  assign wd_tick = tick_pick(st_ff.watchdog_tick_sel, tick_8hz, tick_1hz, tick_half_hz, tick_minute);

  // terminal count compare; the one-shot is frozen while its clock is gated
  assign os_hit = st_ff.oneshot_start && st_ff.gate_on && (st_ff.oneshot_cnt == st_ff.oneshot_limit);
  assign wd_hit = st_ff.watchdog_run && (st_ff.watchdog_cnt == st_ff.watchdog_limit);

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // configuration registers; reserved bits are not stored and read zero
    if (wr_gate) begin
      nxt_st.gate_on = reg_wdata[BIT_GATE_ON];
    end
    if (wr_os_limit) begin
      nxt_st.oneshot_limit = reg_wdata;
    end
    if (wr_wd_limit) begin
      nxt_st.watchdog_limit = reg_wdata;
    end
    if (wr_sel) begin
      nxt_st.oneshot_tick_sel  = reg_wdata[LSB_ONESHOT_SEL +: 2];
      nxt_st.watchdog_tick_sel = reg_wdata[LSB_WATCHDOG_SEL +: 2];
    end
    if (wr_irqen) begin
      nxt_st.oneshot_irq_on  = reg_wdata[BIT_ONESHOT_IRQ];
      nxt_st.watchdog_irq_on = reg_wdata[BIT_WATCHDOG_IRQ];
    end

    // one-shot: gated clock holds counter while gate is off
    if (wr_oneshot) begin
      nxt_st.oneshot_start = reg_wdata[BIT_ONESHOT_START];
      if (!reg_wdata[BIT_ONESHOT_START]) begin
        nxt_st.oneshot_cnt = RST_COUNT;
      end
    end
    if (os_hit) begin
      // timeout beats a one-shot control write in the same cycle, so no count runs past the limit
      nxt_st.oneshot_start = 1'b0;
      nxt_st.oneshot_cnt   = RST_COUNT;
    end else if (st_ff.oneshot_start && st_ff.gate_on && os_tick && !wr_oneshot) begin
      nxt_st.oneshot_cnt = st_ff.oneshot_cnt + 8'h01;
    end

    // watchdog: restart clears the count, run bit written alongside decides
    if (wr_wdog) begin
      nxt_st.watchdog_run = reg_wdata[BIT_WATCHDOG_RUN];
      if (!reg_wdata[BIT_WATCHDOG_RUN] || reg_wdata[BIT_WATCHDOG_RST]) begin
        nxt_st.watchdog_cnt = RST_COUNT;
      end
    end
    if (wd_hit) begin
      nxt_st.watchdog_run = 1'b0;
      nxt_st.watchdog_cnt = RST_COUNT;
    end else if (st_ff.watchdog_run && wd_tick && !wr_wdog) begin
      nxt_st.watchdog_cnt = st_ff.watchdog_cnt + 8'h01;
    end

    // sticky flags: write one clears, a timeout in the same cycle wins
    if (wr_flags && reg_wdata[BIT_ONESHOT_FLAG]) begin
      nxt_st.oneshot_expired_flag = 1'b0;
    end
    if (wr_flags && reg_wdata[BIT_WATCHDOG_FLAG]) begin
      nxt_st.watchdog_expired_flag = 1'b0;
    end
    if (os_hit) begin
      nxt_st.oneshot_expired_flag = 1'b1;
    end
    if (wd_hit) begin
      nxt_st.watchdog_expired_flag = 1'b1;
    end

    // level interrupt follows the next flags so it drops with the clear
    nxt_st.irq = (nxt_st.oneshot_expired_flag && nxt_st.oneshot_irq_on)
              || (nxt_st.watchdog_expired_flag && nxt_st.watchdog_irq_on);

    // read data, registered; restart bit always reads zero
    if (reg_rd) begin
      case (reg_addr)
        OFS_TIMER_GLOBAL_GATE:       nxt_st.rdata = {7'h00, st_ff.gate_on};
        OFS_WATCHDOG_CONTROL:        nxt_st.rdata = {7'h00, st_ff.watchdog_run};
        OFS_ONESHOT_CONTROL:         nxt_st.rdata = {7'h00, st_ff.oneshot_start};
        OFS_TIMER_TIMEOUT_FLAGS:     nxt_st.rdata = {3'h0, st_ff.watchdog_expired_flag,
                                                     3'h0, st_ff.oneshot_expired_flag};
        OFS_ONESHOT_TERMINAL_COUNT:  nxt_st.rdata = st_ff.oneshot_limit;
        OFS_WATCHDOG_TERMINAL_COUNT: nxt_st.rdata = st_ff.watchdog_limit;
        OFS_TICK_SELECT:             nxt_st.rdata = {2'h0, st_ff.watchdog_tick_sel,
                                                     2'h0, st_ff.oneshot_tick_sel};
        OFS_TIMER_IRQ_ENABLES:       nxt_st.rdata = {3'h0, st_ff.watchdog_irq_on,
                                                     3'h0, st_ff.oneshot_irq_on};
        default:                     nxt_st.rdata = RD_UNMAPPED;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{gate_on: 1'b0, oneshot_start: 1'b0, oneshot_cnt: RST_COUNT,
                 oneshot_limit: RST_LIMIT, oneshot_tick_sel: RST_TICK_SEL,
                 oneshot_expired_flag: 1'b0, oneshot_irq_on: 1'b0,
                 watchdog_run: 1'b0, watchdog_cnt: RST_COUNT,
                 watchdog_limit: RST_LIMIT, watchdog_tick_sel: RST_TICK_SEL,
                 watchdog_expired_flag: 1'b0, watchdog_irq_on: 1'b0,
                 irq: 1'b0, rdata: RD_UNMAPPED};
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign timer_irq = st_ff.irq;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_os_hit;
    ce && os_hit;
  endsequence

  sequence s_wd_hit;
    ce && wd_hit;
  endsequence

  sequence s_os_stop_write;
    ce && wr_oneshot && !reg_wdata[BIT_ONESHOT_START];
  endsequence

  AST_OS_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
    s_os_hit |=> st_ff.oneshot_expired_flag)
    else $error("one-shot timeout did not set its flag");

  // a limit written in the timeout cycle itself is a legal update, not a loss
  AST_OS_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    s_os_hit |=> (!st_ff.oneshot_start && st_ff.oneshot_cnt == 8'h00
                  && st_ff.oneshot_limit == ($past(wr_os_limit) ? $past(reg_wdata) : $past(st_ff.oneshot_limit))))
    else $error("one-shot did not stop and clear after timeout");

  AST_OS_WRITE_STOP: assert property (@(posedge clk) disable iff (!rst_b)
    s_os_stop_write |=> (!st_ff.oneshot_start && st_ff.oneshot_cnt == 8'h00))
    else $error("writing start zero did not stop the one-shot");

  AST_OS_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && st_ff.oneshot_start && st_ff.gate_on && !os_hit && os_tick && !wr_oneshot)
      |=> st_ff.oneshot_cnt == $past(st_ff.oneshot_cnt) + 8'h01)
    else $error("one-shot missed a selected tick");

  AST_OS_GATED: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !st_ff.gate_on && !wr_oneshot) |=> $stable(st_ff.oneshot_cnt))
    else $error("one-shot moved while its clock was gated");

  AST_WD_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
    s_wd_hit |=> (st_ff.watchdog_expired_flag && !st_ff.watchdog_run && st_ff.watchdog_cnt == 8'h00))
    else $error("watchdog timeout did not set flag and stop");

  AST_WD_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !wd_hit && wr_wdog && reg_wdata[BIT_WATCHDOG_RST] && reg_wdata[BIT_WATCHDOG_RUN])
      |=> (st_ff.watchdog_cnt == 8'h00 && st_ff.watchdog_run))
    else $error("watchdog restart did not clear and keep running");

  AST_WD_RST_READS_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && reg_rd && reg_addr == OFS_WATCHDOG_CONTROL) |=> reg_rdata[BIT_WATCHDOG_RST] == 1'b0)
    else $error("restart bit read back as one");

  AST_OS_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_flags && reg_wdata[BIT_ONESHOT_FLAG] && !os_hit) |=> !st_ff.oneshot_expired_flag)
    else $error("one-shot flag not cleared by write of one");

  AST_WD_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_flags && !reg_wdata[BIT_WATCHDOG_FLAG] && st_ff.watchdog_expired_flag)
      |=> st_ff.watchdog_expired_flag)
    else $error("watchdog flag lost on write of zero");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    ((st_ff.oneshot_expired_flag && st_ff.oneshot_irq_on)
     || (st_ff.watchdog_expired_flag && st_ff.watchdog_irq_on)) |-> timer_irq)
    else $error("interrupt low while an enabled flag is set");

  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!rst_b)
    (!st_ff.oneshot_irq_on && !st_ff.watchdog_irq_on) |-> !timer_irq)
    else $error("interrupt raised with both enables off");

  AST_LIMIT_RESET: assert property (@(posedge clk)
    $rose(rst_b) |-> (st_ff.oneshot_limit == 8'hff && st_ff.watchdog_limit == 8'hff))
    else $error("terminal counts not all ones after reset");

  // tick routing is spelled out pin by pin so a swapped select code shows up
  AST_OS_TICK_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    os_tick == ((st_ff.oneshot_tick_sel == SEL_TICK0 && tick_32k)
                || (st_ff.oneshot_tick_sel == SEL_TICK1 && tick_1024)
                || (st_ff.oneshot_tick_sel == SEL_TICK2 && tick_1hz)
                || (st_ff.oneshot_tick_sel == SEL_TICK3 && tick_minute)))
    else $error("one-shot counts on the wrong tick");

  AST_WD_TICK_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    wd_tick == ((st_ff.watchdog_tick_sel == SEL_TICK0 && tick_8hz)
                || (st_ff.watchdog_tick_sel == SEL_TICK1 && tick_1hz)
                || (st_ff.watchdog_tick_sel == SEL_TICK2 && tick_half_hz)
                || (st_ff.watchdog_tick_sel == SEL_TICK3 && tick_minute)))
    else $error("watchdog counts on the wrong tick");

  AST_WD_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && st_ff.watchdog_run && !wd_hit && wd_tick && !wr_wdog)
      |=> st_ff.watchdog_cnt == $past(st_ff.watchdog_cnt) + 8'h01)
    else $error("watchdog missed a selected tick");

  AST_WD_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !wd_hit && wr_wdog && reg_wdata[BIT_WATCHDOG_RST] && !st_ff.watchdog_expired_flag)
      |=> !st_ff.watchdog_expired_flag)
    else $error("watchdog restart let a timeout through");

  AST_WD_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_flags && reg_wdata[BIT_WATCHDOG_FLAG] && !wd_hit) |=> !st_ff.watchdog_expired_flag)
    else $error("watchdog flag not cleared by write of one");

  AST_OS_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_flags && !reg_wdata[BIT_ONESHOT_FLAG] && st_ff.oneshot_expired_flag)
      |=> st_ff.oneshot_expired_flag)
    else $error("one-shot flag lost on write of zero");

  AST_IRQ_DROP: assert property (@(posedge clk) disable iff (!rst_b)
    !((st_ff.oneshot_expired_flag && st_ff.oneshot_irq_on)
      || (st_ff.watchdog_expired_flag && st_ff.watchdog_irq_on)) |-> !timer_irq)
    else $error("interrupt high with no enabled flag set");

  AST_OS_LIMIT_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_os_limit) |=> st_ff.oneshot_limit == $past(reg_wdata))
    else $error("one-shot terminal count write not stored");

  AST_WD_LIMIT_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && wr_wd_limit) |=> st_ff.watchdog_limit == $past(reg_wdata))
    else $error("watchdog terminal count write not stored");

  AST_GATE_KEEPS: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && !st_ff.gate_on && !wr_sel && !wr_os_limit)
      |=> ($stable(st_ff.oneshot_limit) && $stable(st_ff.oneshot_tick_sel)))
    else $error("one-shot settings lost while its clock was gated");
endmodule : timer_block

/* File: tb/timer_block_test.sv */
// self-checking bench for the one-shot and watchdog timer block
// assumes timer_pkg and timer_block are compiled first; bench drives ports and ticks itself
`timescale 1ns/100ps
module timer_block_test;
  import timer_pkg::*;
  // ---------------------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------------------
  logic       clk;
  logic       rst_b;
  logic       ce;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [5:0] ticks;           // 32k, 1024, 8 Hz, 1 Hz, 0.5 Hz, minute
  logic       timer_irq;
  int         n_errors;
  int         comparisons;
  int         m_flags;         // model of the timeout flags
  int         m_en;            // model of the interrupt enables
  int         m_sel [2];       // model of both tick selects
  int         os_map [4] = '{0, 1, 3, 5};
  int         wd_map [4] = '{2, 3, 4, 5};
  logic [7:0] rst_adr [9] = '{8'h3a, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7};
  logic [7:0] rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  int         n;
  logic [7:0] v;

  timer_block uut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tick_32k(ticks[0]), .tick_1024(ticks[1]),
    .tick_8hz(ticks[2]), .tick_1hz(ticks[3]), .tick_half_hz(ticks[4]), .tick_minute(ticks[5]),
    .timer_irq(timer_irq)
  );

  // ---------------------------------------------------------------------------
  // helpers; every access leaves a quiet cycle so no strobe is set twice at once
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] ctl(input int w);
    return w ? OFS_WATCHDOG_CONTROL : OFS_ONESHOT_CONTROL;
  endfunction : ctl

  function automatic logic [7:0] lim(input int w);
    return w ? OFS_WATCHDOG_TERMINAL_COUNT : OFS_ONESHOT_TERMINAL_COUNT;
  endfunction : lim

  function automatic int tk(input int w);
    return w ? wd_map[m_sel[1]] : os_map[m_sel[0]];
  endfunction : tk

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic idle();
    @(posedge clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    idle();
    reg_wr = 1'b0;
    idle();
  endtask : wr

  // read data is registered at the read edge; irq is checked against the model too
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    idle();
    reg_rd = 1'b0;
    check(reg_rdata, exp, "read data");
    check({7'h0, timer_irq}, ((m_flags & m_en) != 0) ? 8'h01 : 8'h00, "irq level");
    idle();
  endtask : rd

  task automatic pulse(input int i);
    ticks[i] = 1'b1;
    idle();
    ticks = 6'h0;
    idle();
  endtask : pulse

  // foreign ticks first, then n-1 real ticks with no timeout, then the last one
  task automatic run_timer(input int w, input int s, input int cnt);
    m_sel[w] = s;
    wr(lim(w), 8'(cnt));
    wr(OFS_TICK_SELECT, 8'(m_sel[0] + 16 * m_sel[1]));
    wr(ctl(w), 8'h01);
    for (int i = 0; i < 6; i++) begin
      if (i != tk(w)) pulse(i);
    end
    if (cnt > 0) begin
      repeat (cnt - 1) pulse(tk(w));
      rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h00);
      pulse(tk(w));
    end
    idle();
    m_flags = w ? 16 : 1;
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'(m_flags));
  endtask : run_timer

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole run is a few hundred cycles; this cuts a hang short
  initial begin
    #300000;
    n_errors++;
    $display("BAD %0t run did not finish", $time);
    summarize();
  end

  initial begin
    rst_b = 1'b0; ce = 1'b1; reg_addr = 8'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_wdata = 8'h0; ticks = 6'h0; n_errors = 0; comparisons = 0;
    m_flags = 0; m_en = 0; m_sel[0] = 0; m_sel[1] = 0;
    void'($urandom(80));
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 9; i++) rd(rst_adr[i], rst_val[i]);
    v = 8'($urandom);
    wr(OFS_ONESHOT_TERMINAL_COUNT, v);
    rd(OFS_ONESHOT_TERMINAL_COUNT, v);
    wr(OFS_WATCHDOG_TERMINAL_COUNT, ~v);
    rd(OFS_WATCHDOG_TERMINAL_COUNT, ~v);
    wr(OFS_TICK_SELECT, 8'hff);
    rd(OFS_TICK_SELECT, 8'h33);
    m_en = 8'h11;
    wr(OFS_TIMER_IRQ_ENABLES, 8'hff);
    rd(OFS_TIMER_IRQ_ENABLES, 8'h11);
    wr(OFS_TIMER_GLOBAL_GATE, 8'h01);
    rd(OFS_TIMER_GLOBAL_GATE, 8'h01);
    // every tick code of both timers, code 0 only with a zero count and no tick, interrupts on for odd codes only
    for (int w = 0; w < 2; w++) begin
      for (int s = 0; s < 4; s++) begin
        n = (s == 0) ? 0 : $urandom_range(4, 1);
        m_en = (s % 2) ? 8'h11 : 8'h00;
        wr(OFS_TIMER_IRQ_ENABLES, 8'(m_en));
        run_timer(w, s, n);
        rd(ctl(w), 8'h00);
        rd(lim(w), 8'(n));
        wr(OFS_TIMER_TIMEOUT_FLAGS, 8'h00);
        rd(OFS_TIMER_TIMEOUT_FLAGS, 8'(m_flags));
        m_flags = 0;
        wr(OFS_TIMER_TIMEOUT_FLAGS, w ? 8'h10 : 8'h01);
        rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h00);
      end
    end
    // stop mid-count: a restart needs the full count again
    wr(OFS_ONESHOT_TERMINAL_COUNT, 8'h03);
    wr(OFS_ONESHOT_CONTROL, 8'h01);
    repeat (2) pulse(tk(0));
    wr(OFS_ONESHOT_CONTROL, 8'h00);
    rd(OFS_ONESHOT_CONTROL, 8'h00);
    wr(OFS_ONESHOT_CONTROL, 8'h01);
    repeat (2) pulse(tk(0));
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h00);
    pulse(tk(0));
    idle();
    m_flags = 1;
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h01);
    m_flags = 0;
    wr(OFS_TIMER_TIMEOUT_FLAGS, 8'h01);
    // watchdog restart before expiry keeps it counting from zero
    wr(OFS_WATCHDOG_TERMINAL_COUNT, 8'h03);
    wr(OFS_WATCHDOG_CONTROL, 8'h01);
    repeat (2) pulse(tk(1));
    wr(OFS_WATCHDOG_CONTROL, 8'h11);
    rd(OFS_WATCHDOG_CONTROL, 8'h01);
    repeat (2) pulse(tk(1));
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h00);
    pulse(tk(1));
    idle();
    m_flags = 16;
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h10);
    m_flags = 0;
    wr(OFS_TIMER_TIMEOUT_FLAGS, 8'h10);
    // gate off freezes the one-shot, settings survive
    wr(OFS_TIMER_GLOBAL_GATE, 8'h00);
    wr(OFS_ONESHOT_TERMINAL_COUNT, 8'h02);
    wr(OFS_ONESHOT_CONTROL, 8'h01);
    repeat (4) pulse(tk(0));
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h00);
    rd(OFS_ONESHOT_TERMINAL_COUNT, 8'h02);
    wr(OFS_TIMER_GLOBAL_GATE, 8'h01);
    repeat (2) pulse(tk(0));
    idle();
    m_flags = 1;
    rd(OFS_TIMER_TIMEOUT_FLAGS, 8'h01);
    // clock enable low ignores a write
    ce = 1'b0;
    wr(OFS_ONESHOT_TERMINAL_COUNT, 8'h5a);
    ce = 1'b1;
    rd(OFS_ONESHOT_TERMINAL_COUNT, 8'h02);
    summarize();
  end
endmodule : timer_block_test
